// ### hdl/fit_pkg.sv
// ----------------------------------------
// Shared constants
// ----------------------------------------
package fit_pkg;

	// Pin counts
	localparam int FIT_FLAG_NUM = 4;
	localparam int FIT_IRQ_NUM = 4;

	// Synchroniser depth for asynchronous pins
	localparam int FIT_SYNC_STAGES = 2;

	// Timer expired pulse length in system clock cycles
	localparam int FIT_TMR_PULSE_CYCLES = 4;
	localparam int FIT_TMR_CNT_W = 3;
	localparam logic [FIT_TMR_CNT_W-1:0] FIT_TMR_CNT_LOAD = FIT_TMR_PULSE_CYCLES[FIT_TMR_CNT_W-1:0];
	localparam logic [FIT_TMR_CNT_W-1:0] FIT_TMR_CNT_ONE = 3'h1;
	localparam logic [FIT_TMR_CNT_W-1:0] FIT_TMR_CNT_ZERO = 3'h0;

	// Values after reset
	localparam logic [FIT_FLAG_NUM-1:0] FIT_FLAG_OE_RESET = 4'h0;
	localparam logic [FIT_FLAG_NUM-1:0] FIT_FLAG_DRV_RESET = 4'h0;
	localparam logic [FIT_IRQ_NUM-1:0] FIT_IRQ_EN_RESET = 4'h0;
	localparam logic [FIT_IRQ_NUM-1:0] FIT_IRQ_EN_BOOT = 4'hF;
	localparam logic [FIT_IRQ_NUM-1:0] FIT_IRQ_ZERO = 4'h0;

	// Idle level of the synchronised pins (flags pulled down, requests pulled up)
	localparam logic [FIT_FLAG_NUM+FIT_IRQ_NUM-1:0] FIT_SYNC_RESET = 8'hF0;

endpackage : fit_pkg

// ### hdl/fit_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// Multi-bit level synchroniser
// ----------------------------------------
module fit_sync #(
	parameter int WIDTH = 8,
	parameter int STAGES = 2,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Asynchronous levels
	input wire logic [WIDTH-1:0] async_in,
	// Synchronised levels
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [STAGES-1:0][WIDTH-1:0] stage;
	} fit_sync_state_t;

	fit_sync_state_t sync_reg;
	fit_sync_state_t sync_next;

	// ----------------------------------------
	// Shift chain, first stage read only by the second
	// ----------------------------------------
	always_comb begin
		sync_next = sync_reg;
		sync_next.stage[0] = async_in;
		for (int i = 1; i < STAGES; i++) begin
			sync_next.stage[i] = sync_reg.stage[i-1];
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			sync_reg <= {STAGES{RESET_VALUE}};
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg.stage[STAGES-1];

endmodule // fit_sync

// ### hdl/fit_pins.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Each flag pin has its own direction.
// R2: Flag levels offered as core test conditions.
// R3: Flags are inputs at power-up and reset.
// R4: Asserted enabled request raises core interrupt.
// R5: Each request chooses edge or level sensing.
// R6: Requests disabled after reset unless boot strap.
// R7: Timer expiry drives output four cycles exactly.
// R8: Timer pin sampled as strap during reset; code samples it on the first edge after reset release.
// R9: Asynchronous pins pass two register stages first.
module fit_pins (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Flag pins
	input wire logic [fit_pkg::FIT_FLAG_NUM-1:0] program_flag_pins_in,
	output logic [fit_pkg::FIT_FLAG_NUM-1:0] program_flag_pins_out,
	output logic [fit_pkg::FIT_FLAG_NUM-1:0] program_flag_pins_oe_out,
	// Flag control from the sequencer
	input wire logic [fit_pkg::FIT_FLAG_NUM-1:0] flag_dir_output_in,
	input wire logic [fit_pkg::FIT_FLAG_NUM-1:0] flag_drive_value_in,
	// Flag conditions to the sequencer
	output logic [fit_pkg::FIT_FLAG_NUM-1:0] flag_condition_out,
	// Interrupt request pins, active low
	input wire logic [fit_pkg::FIT_IRQ_NUM-1:0] external_interrupt_request_pins_n_in,
	// Interrupt control from the core
	input wire logic irq_enable_write_in,
	input wire logic [fit_pkg::FIT_IRQ_NUM-1:0] irq_enable_value_in,
	input wire logic [fit_pkg::FIT_IRQ_NUM-1:0] irq_edge_mode_in,
	input wire logic [fit_pkg::FIT_IRQ_NUM-1:0] irq_ack_in,
	// Interrupt status to the core
	output logic [fit_pkg::FIT_IRQ_NUM-1:0] irq_request_out,
	output logic [fit_pkg::FIT_IRQ_NUM-1:0] irq_enable_out,
	// Boot strap level for interrupt booting
	input wire logic irq_boot_strap_in,
	// Timer expired pin
	input wire logic timer_expire_in,
	input wire logic timer_zero_expired_in,
	output logic timer_zero_expired_out,
	output logic timer_zero_expired_oe_out,
	// Strap results
	output logic timer_strap_out,
	output logic strap_valid_out
);

	import fit_pkg::*;

	typedef struct packed {
		logic [FIT_FLAG_NUM-1:0] flag_oe;
		logic [FIT_FLAG_NUM-1:0] flag_drv;
		logic [FIT_FLAG_NUM-1:0] flag_cond;
		logic [FIT_IRQ_NUM-1:0] irq_prev;
		logic [FIT_IRQ_NUM-1:0] irq_latch;
		logic [FIT_IRQ_NUM-1:0] irq_req;
		logic [FIT_IRQ_NUM-1:0] irq_en;
		logic strap_done;
		logic tmr_strap;
		logic tmr_oe;
		logic tmr_out;
		logic [FIT_TMR_CNT_W-1:0] tmr_cnt;
	} fit_state_t;

	fit_state_t state_reg;
	fit_state_t state_next;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [FIT_FLAG_NUM+FIT_IRQ_NUM-1:0] pins_sync;
	logic [FIT_FLAG_NUM-1:0] flag_sync;
	logic [FIT_IRQ_NUM-1:0] irq_asserted;

	fit_sync #(
		.WIDTH(FIT_FLAG_NUM + FIT_IRQ_NUM),
		.STAGES(FIT_SYNC_STAGES),
		.RESET_VALUE(FIT_SYNC_RESET)
	) u_sync (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.async_in({external_interrupt_request_pins_n_in, program_flag_pins_in}), // R9
		.sync_out(pins_sync)
	);

	assign flag_sync = pins_sync[FIT_FLAG_NUM-1:0];
	assign irq_asserted = ~pins_sync[FIT_FLAG_NUM+FIT_IRQ_NUM-1:FIT_FLAG_NUM];

	// ----------------------------------------
	// Per-flag condition source
	// ----------------------------------------
	logic [FIT_FLAG_NUM-1:0] flag_cond_next;

	for (genvar f = 0; f < FIT_FLAG_NUM; f++) begin : g_flag
		logic drives_pin;
		assign drives_pin = state_reg.flag_oe[f];
		assign flag_cond_next[f] = drives_pin ? state_reg.flag_drv[f] : flag_sync[f]; // R2
	end

	// ----------------------------------------
	// Per-request sensing
	// ----------------------------------------
	logic [FIT_IRQ_NUM-1:0] irq_edge_seen;
	logic [FIT_IRQ_NUM-1:0] irq_latch_next;
	logic [FIT_IRQ_NUM-1:0] irq_req_next;

	for (genvar g = 0; g < FIT_IRQ_NUM; g++) begin : g_irq
		logic edge_armed;
		logic level_armed;
		assign edge_armed = state_reg.irq_en[g] & irq_edge_mode_in[g];
		assign level_armed = state_reg.irq_en[g] & ~irq_edge_mode_in[g];
		assign irq_edge_seen[g] = irq_asserted[g] & ~state_reg.irq_prev[g];
		assign irq_latch_next[g] = edge_armed
			& (irq_edge_seen[g] | (state_reg.irq_latch[g] & ~irq_ack_in[g])); // R5
		assign irq_req_next[g] = (edge_armed & irq_latch_next[g])
			| (level_armed & irq_asserted[g]); // R4
	end

	// ----------------------------------------
	// Timer pulse qualifiers
	// ----------------------------------------
	logic tmr_start;
	logic tmr_more;

	assign tmr_start = state_reg.strap_done & timer_expire_in; // R7
	assign tmr_more = state_reg.tmr_cnt > FIT_TMR_CNT_ONE;

	// ----------------------------------------
	// Strap capture qualifiers
	// ----------------------------------------
	logic strap_take;
	logic [FIT_IRQ_NUM-1:0] irq_en_boot;

	assign strap_take = ~state_reg.strap_done; // R8
	assign irq_en_boot = irq_boot_strap_in ? FIT_IRQ_EN_BOOT : FIT_IRQ_EN_RESET; // R6

	// ----------------------------------------
	// Interrupt enable source
	// ----------------------------------------
	logic [FIT_IRQ_NUM-1:0] irq_en_write;

	assign irq_en_write = irq_enable_write_in ? irq_enable_value_in : state_reg.irq_en;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;

		// Flag direction and drive, each pin on its own
		state_next.flag_oe = flag_dir_output_in; // R1
		state_next.flag_drv = flag_drive_value_in;

		// Condition follows the pin when input, the driven value when output
		state_next.flag_cond = flag_cond_next; // R2

		// Strap capture on the first edge after reset release
		if (strap_take) begin
			state_next.strap_done = 1'b1;
			state_next.tmr_strap = timer_zero_expired_in; // R8
			state_next.tmr_oe = 1'b1; // R8
			state_next.irq_en = irq_en_boot; // R6
		end else begin
			state_next.irq_en = irq_en_write;
		end

		// Edge detection history
		state_next.irq_prev = irq_asserted;

		// Edge latch: new edge wins over acknowledge
		state_next.irq_latch = irq_latch_next; // R5

		// Request to the core, edge or level per input
		state_next.irq_req = irq_req_next; // R4

		// Timer expired pulse, restarted by a new expiry
		if (tmr_start) begin
			state_next.tmr_out = 1'b1; // R7
			state_next.tmr_cnt = FIT_TMR_CNT_LOAD; // R7
		end else if (tmr_more) begin
			state_next.tmr_cnt = state_reg.tmr_cnt - FIT_TMR_CNT_ONE; // R7
		end else begin
			state_next.tmr_out = 1'b0; // R7
			state_next.tmr_cnt = FIT_TMR_CNT_ZERO;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg.flag_oe <= FIT_FLAG_OE_RESET; // R3
			state_reg.flag_drv <= FIT_FLAG_DRV_RESET;
			state_reg.flag_cond <= FIT_FLAG_DRV_RESET;
			state_reg.irq_prev <= FIT_IRQ_ZERO;
			state_reg.irq_latch <= FIT_IRQ_ZERO;
			state_reg.irq_req <= FIT_IRQ_ZERO;
			state_reg.irq_en <= FIT_IRQ_EN_RESET; // R6
			state_reg.strap_done <= 1'b0;
			state_reg.tmr_strap <= 1'b0;
			state_reg.tmr_oe <= 1'b0; // R8
			state_reg.tmr_out <= 1'b0;
			state_reg.tmr_cnt <= FIT_TMR_CNT_ZERO;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign program_flag_pins_out = state_reg.flag_drv;
	assign program_flag_pins_oe_out = state_reg.flag_oe;
	assign flag_condition_out = state_reg.flag_cond;

	// ----------------------------------------
	// Interrupt outputs
	// ----------------------------------------
	assign irq_request_out = state_reg.irq_req;
	assign irq_enable_out = state_reg.irq_en;

	// ----------------------------------------
	// Timer and strap outputs
	// ----------------------------------------
	assign timer_zero_expired_out = state_reg.tmr_out;
	assign timer_zero_expired_oe_out = state_reg.tmr_oe;
	assign timer_strap_out = state_reg.tmr_strap;
	assign strap_valid_out = state_reg.strap_done;

endmodule // fit_pins

// ### hdl/unused_placeholder_none.sv
`timescale 1ns/1ps
// ----------------------------------------
// Intentionally empty unit
// ----------------------------------------

// ### bench/fit_board.sv
`timescale 1ns/1ps
// --
// Board side of flag and request pins
// --
module fit_board (
	// Device drive
	input logic [3:0] dev_oe_in,
	input logic [3:0] dev_val_in,
	// Board drive
	input logic [3:0] ext_en_in,
	input logic [3:0] ext_val_in,
	input logic [3:0] irq_low_in,
	// Pin levels
	output logic [3:0] flag_pins_out,
	output logic [3:0] irq_pins_n_out
);
	// Flags pulled down, requests pulled up when released
	assign flag_pins_out = (dev_oe_in & dev_val_in) | (~dev_oe_in & ext_en_in & ext_val_in);
	assign irq_pins_n_out = ~irq_low_in;
endmodule // fit_board

// ### bench/fit_pins_sva.sv
`timescale 1ns/1ps
module fit_pins_sva (
	// Watched ports
	input logic mclk_in,
	input logic reset_in,
	input logic [3:0] program_flag_pins_oe_out,
	input logic [3:0] flag_dir_output_in,
	input logic [3:0] irq_request_out,
	input logic [3:0] irq_enable_out,
	input logic irq_boot_strap_in,
	input logic timer_expire_in,
	input logic timer_zero_expired_out,
	input logic timer_zero_expired_oe_out,
	input logic strap_valid_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	a_flag_dir: assert property (!$past(reset_in) |->
		program_flag_pins_oe_out == $past(flag_dir_output_in)) else $error("flag dir");
	a_flag_reset: assert property (disable iff (1'b0) reset_in |->
		!timer_zero_expired_oe_out && program_flag_pins_oe_out == 4'h0) else $error("reset dir");
	a_irq_gate: assert property ((irq_request_out & ~irq_enable_out
		& ~$past(irq_enable_out)) == 4'h0) else $error("irq gate");
	a_boot_en: assert property ($past(reset_in, 2) && !$past(reset_in) |->
		irq_enable_out == {4{$past(irq_boot_strap_in)}}) else $error("boot en");
	a_strap_take: assert property ($past(reset_in, 2) && !$past(reset_in) |->
		strap_valid_out && timer_zero_expired_oe_out) else $error("strap");
	a_tmr_pulse: assert property (timer_expire_in && strap_valid_out |=>
		timer_zero_expired_out [*4]) else $error("tmr pulse");
	a_tmr_end: assert property ((!timer_expire_in) [*4] |=>
		!timer_zero_expired_out) else $error("tmr end");
	a_oe_hold: assert property ($stable(flag_dir_output_in) [*2] ##0 !$past(reset_in, 2) |->
		$stable(program_flag_pins_oe_out)) else $error("oe hold");
	cover property (timer_zero_expired_out);
	cover property (|irq_request_out);
	cover property (strap_valid_out);
endmodule // fit_pins_sva
bind fit_pins fit_pins_sva fit_pins_sva_inst (.*);

// ### bench/fit_pins_tb.sv
`timescale 1ns/1ps
module fit_pins_tb;
	logic mclk_in, reset_in, irq_enable_write_in, irq_boot_strap_in, timer_expire_in, strap_pin;
	logic timer_zero_expired_in, timer_zero_expired_out, timer_zero_expired_oe_out;
	logic timer_strap_out, strap_valid_out;
	logic [3:0] program_flag_pins_in, program_flag_pins_out, program_flag_pins_oe_out, ext_en;
	logic [3:0] flag_dir_output_in, flag_drive_value_in, flag_condition_out, ext_val, irq_low;
	logic [3:0] external_interrupt_request_pins_n_in, irq_enable_value_in, irq_edge_mode_in;
	logic [3:0] irq_ack_in, irq_request_out, irq_enable_out;
	int bad_count = 0;
	int n_checks = 0;
	fit_pins fit_pins_inst (.*);
	fit_board fit_board_inst (.dev_oe_in(program_flag_pins_oe_out),
		.dev_val_in(program_flag_pins_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
		.irq_low_in(irq_low), .flag_pins_out(program_flag_pins_in),
		.irq_pins_n_out(external_interrupt_request_pins_n_in));
	// Timer pin pulled to the strap level while the device leaves it
	assign timer_zero_expired_in = timer_zero_expired_oe_out ? timer_zero_expired_out : strap_pin;
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic do_reset(input logic boot, input logic strap);
		@(posedge mclk_in);
		reset_in <= 1'b1;
		irq_boot_strap_in <= boot;
		strap_pin <= strap;
		cyc(6);
		chk("oe in reset", 4'h0, program_flag_pins_oe_out);
		chk("tmr oe in reset", 4'h0, {3'h0, timer_zero_expired_oe_out});
		reset_in <= 1'b0;
		cyc(2);
		@(negedge mclk_in);
		chk("irq enable", {4{boot}}, irq_enable_out);
		chk("tmr oe", 4'h1, {3'h0, timer_zero_expired_oe_out});
		chk("strap valid", 4'h1, {3'h0, strap_valid_out});
		chk("strap", {3'h0, strap}, {3'h0, timer_strap_out});
	endtask
	task automatic t_flags;
		@(posedge mclk_in);
		flag_dir_output_in <= 4'h5;
		flag_drive_value_in <= 4'h1;
		ext_en <= 4'hA;
		ext_val <= 4'h8;
		cyc(4);
		@(negedge mclk_in);
		chk("flag oe", 4'h5, program_flag_pins_oe_out);
		chk("flag out", 4'h1, program_flag_pins_out);
		chk("flag cond", 4'h9, flag_condition_out);
		@(posedge mclk_in);
		ext_val <= 4'h2;
		cyc(2);
		@(negedge mclk_in);
		chk("cond early", 4'h9, flag_condition_out);
		@(negedge mclk_in);
		chk("cond late", 4'h3, flag_condition_out);
	endtask
	task automatic t_irq;
		@(posedge mclk_in);
		irq_enable_write_in <= 1'b1;
		irq_enable_value_in <= 4'h3;
		irq_edge_mode_in <= 4'h1;
		@(posedge mclk_in);
		irq_enable_write_in <= 1'b0;
		irq_low <= 4'h7;
		cyc(5);
		irq_low <= 4'h0;
		@(negedge mclk_in);
		chk("irq held", 4'h3, irq_request_out);
		cyc(5);
		@(negedge mclk_in);
		chk("irq latch", 4'h1, irq_request_out);
		@(posedge mclk_in);
		irq_ack_in <= 4'h1;
		@(posedge mclk_in);
		irq_ack_in <= 4'h0;
		cyc(2);
		@(negedge mclk_in);
		chk("irq ack", 4'h0, irq_request_out);
	endtask
	task automatic t_timer;
		int n = 0;
		@(posedge mclk_in);
		timer_expire_in <= 1'b1;
		@(posedge mclk_in);
		timer_expire_in <= 1'b0;
		repeat (10) begin
			@(negedge mclk_in);
			if (timer_zero_expired_out === 1'b1)
				n++;
		end
		chk("pulse", 4'h4, n[3:0]);
	endtask
	initial begin
		{reset_in, irq_enable_write_in, irq_boot_strap_in, timer_expire_in, strap_pin} = 5'h00;
		{flag_dir_output_in, flag_drive_value_in, ext_en, ext_val} = 16'h0000;
		{irq_enable_value_in, irq_edge_mode_in, irq_ack_in, irq_low} = 16'h0000;
		do_reset(1'b0, 1'b1);
		t_flags;
		t_irq;
		t_timer;
		do_reset(1'b1, 1'b0);
		conclude;
	end
endmodule // fit_pins_tb
